// File: pkg/trc_consts.svh
// Character codes, command codes and frame lengths of the command block
`ifndef TRC_CONSTS_SVH
`define TRC_CONSTS_SVH

`define TRC_CHAR_CR      8'h0D
`define TRC_CHAR_ZERO    8'h30
`define TRC_CHAR_ALPHA   8'h37
`define TRC_CMD_PROTECT  16'h3035
`define TRC_CMD_TEST     16'h3130
`define TRC_CMD_ACK      16'h3131
`define TRC_CMD_NACK     16'h3132
`define TRC_CMD_STOP     16'h3133
`define TRC_CMD_CAR_ON   16'h3134
`define TRC_CMD_CAR_OFF  16'h3135
`define TRC_LEN_DONE     6'h03
`define TRC_LEN_PROTECT  6'h0B
`define TRC_ECHO_START   6'h02
`define TRC_ECHO_LAST    6'h3E
`define TRC_RESP_DEPTH   64
`define TRC_FIFO_DEPTH   16
`define TRC_CHAR_WIDTH   8

`endif

// File: pkg/trc_pkg.sv
// Types shared by the command block
`default_nettype none
package trc_pkg;

    typedef enum logic [2:0] {
        TRC_ST_CODE0,
        TRC_ST_CODE1,
        TRC_ST_BODY,
        TRC_ST_BUILD,
        TRC_ST_SEND_RD,
        TRC_ST_SEND_PUSH
    } trc_state_type;

    typedef enum logic [1:0] {
        TRC_RESP_DONE,
        TRC_RESP_PROTECT,
        TRC_RESP_ECHO
    } trc_resp_type;

endpackage : trc_pkg
`default_nettype wire

// File: src/trc_resp_mem.sv
// Response store, one write port and a registered read port
`default_nettype none
module trc_resp_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 64,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic             clk,
    input  wire logic             ce,
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);

    logic [WIDTH-1:0] store [DEPTH];

    // Write and registered read, no reset on the array
    always_ff @(posedge clk) begin
        if (ce) begin
            if (wr_en) begin
                store[wr_addr] <= wr_data;
            end
            rd_data <= store[rd_addr];
        end
    end

endmodule : trc_resp_mem
`default_nettype wire

// File: src/trc_fifo.sv
// Character FIFO between the interpreter and the host link
`default_nettype none
module trc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             ce,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    logic [WIDTH-1:0] slot [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      next_count;
    logic             push;
    logic             pop;

    assign in_ready  = (count != DEPTH[AW:0]);
    assign out_valid = (count != '0);
    assign out_data  = slot[rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Pointer and fill level update
    always_comb begin
        next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
        next_count  = count;
        if (push && !pop) begin
            next_count = (AW + 1)'(count + 1'b1);
        end else if (pop && !push) begin
            next_count = (AW + 1)'(count - 1'b1);
        end
    end

    // Register pointers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else if (ce) begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    // Storage array
    always_ff @(posedge clk) begin
        if (ce && push) begin
            slot[wr_ptr] <= in_data;
        end
    end

endmodule : trc_fifo
`default_nettype wire

// File: src/trc_cmd.sv
// Control command interpreter of the tag reader host protocol
`include "trc_consts.svh"
`default_nettype none
module trc_cmd
    import trc_pkg::*;
#(
    parameter int CW     = `TRC_CHAR_WIDTH,
    parameter int DEPTH  = `TRC_RESP_DEPTH,
    parameter int FDEPTH = `TRC_FIFO_DEPTH
) (
    input  wire logic          clk,
    input  wire logic          rst_b,
    input  wire logic          ce,
    input  wire logic          rx_valid,
    output logic               rx_ready,
    input  wire logic [CW-1:0] rx_data,
    output logic               tx_valid,
    input  wire logic          tx_ready,
    output logic      [CW-1:0] tx_data,
    output logic               carrier_on,
    output logic               protect_req,
    output logic      [31:0]   protect_pages,
    input  wire logic          protect_done,
    input  wire logic [29:0]   protect_status,
    output logic               cmd_busy,
    output logic               abort_pulse,
    output logic               ack_pulse
);

    ////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Nibble to upper-case hex character
    function automatic logic [7:0] hex_char(input logic [3:0] nib);
        logic [7:0] base;
        base = (nib < 4'hA) ? `TRC_CHAR_ZERO : `TRC_CHAR_ALPHA;
        return 8'(base + {4'h0, nib});
    endfunction : hex_char

    // Hex character to nibble, characters other than 0-9, A-F and a-f read as zero
    function automatic logic [3:0] hex_val(input logic [7:0] c);
        logic [3:0] v;
        v = 4'h0;
        if (c >= 8'h30 && c <= 8'h39) begin
            v = c[3:0];
        end else if ((c | 8'h20) >= 8'h61 && (c | 8'h20) <= 8'h66) begin
            v = 4'(c[3:0] + 4'h9);
        end
        return v;
    endfunction : hex_val

    ////////////////////////////////////////////////////////////////////////
    // State

    trc_state_type    state;
    trc_resp_type     kind;
    logic [15:0]      code;
    logic [5:0]       ptr;
    logic [5:0]       resp_len;
    logic             prot_busy;
    logic             prot_have;
    logic [29:0]      prot_bits;
    logic [31:0]      prot_arg;
    logic             car;
    logic             req_q;
    logic             abort_q;
    logic             ack_q;

    trc_state_type    next_state;
    trc_resp_type     next_kind;
    logic [15:0]      next_code;
    logic [5:0]       next_ptr;
    logic [5:0]       next_resp_len;
    logic             next_prot_busy;
    logic             next_prot_have;
    logic [29:0]      next_prot_bits;
    logic [31:0]      next_prot_arg;
    logic             next_car;
    logic             next_req_q;
    logic             next_abort_q;
    logic             next_ack_q;

    logic             mem_wr;
    logic [5:0]       mem_waddr;
    logic [7:0]       mem_wdata;
    logic [7:0]       mem_rdata;
    logic             fifo_ready;
    logic             fifo_push;
    logic             rx_take;
    logic [31:0]      bitmap;
    logic [7:0]       build_char;

    ////////////////////////////////////////////////////////////////////////
    // Response building

    assign bitmap = {prot_bits, 2'b00};
    // No take in TRC_ST_CODE0 while a protection result waits to be built
    assign rx_ready = (state == TRC_ST_CODE0 && !prot_have)
                    || (state == TRC_ST_CODE1) || (state == TRC_ST_BODY);
    assign rx_take  = rx_valid & rx_ready;
    assign fifo_push = (state == TRC_ST_SEND_PUSH);

    // Character of the response at the build index
    always_comb begin
        build_char = `TRC_CHAR_ZERO;
        if (ptr == 6'(resp_len - 1'b1)) begin
            build_char = `TRC_CHAR_CR;
        end else if (kind == TRC_RESP_PROTECT && ptr >= 6'h02) begin
            build_char = hex_char(4'(bitmap >> (5'(6'h09 - ptr) * 3'd4)));
        end
    end

    // Response store write port
    always_comb begin
        mem_wr    = 1'b0;
        mem_waddr = ptr;
        mem_wdata = rx_data;
        if (state == TRC_ST_BODY && rx_take && rx_data != `TRC_CHAR_CR
            && code == `TRC_CMD_TEST && ptr <= `TRC_ECHO_LAST) begin
            mem_wr = 1'b1;
        end else if (state == TRC_ST_BUILD) begin
            mem_wdata = build_char;
            mem_wr    = (kind != TRC_RESP_ECHO) || (ptr < 6'h02)
                      || (ptr == 6'(resp_len - 1'b1));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command sequencer

    // Next state of parser, executor and sender
    always_comb begin
        next_state     = state;
        next_kind      = kind;
        next_code      = code;
        next_ptr       = ptr;
        next_resp_len  = resp_len;
        next_prot_busy = prot_busy;
        next_prot_have = prot_have;
        next_prot_bits = prot_bits;
        next_prot_arg  = prot_arg;
        next_car       = car;
        next_req_q     = 1'b0;
        next_abort_q   = 1'b0;
        next_ack_q     = 1'b0;
        if (prot_busy && protect_done) begin
            next_prot_have = 1'b1;
            next_prot_bits = protect_status;
        end
        unique case (state)
            TRC_ST_CODE0: begin
                if (prot_have) begin
                    next_prot_have = 1'b0;
                    next_prot_busy = 1'b0;
                    next_kind      = TRC_RESP_PROTECT;
                    next_resp_len  = `TRC_LEN_PROTECT;
                    next_ptr       = 6'h00;
                    next_state     = TRC_ST_BUILD;
                end else if (rx_take && rx_data != `TRC_CHAR_CR) begin
                    next_code  = {rx_data, 8'h00};
                    next_state = TRC_ST_CODE1;
                end
            end
            TRC_ST_CODE1: begin
                if (rx_take) begin
                    next_code     = {code[15:8], rx_data};
                    next_ptr      = `TRC_ECHO_START;
                    next_state    = (rx_data == `TRC_CHAR_CR) ? TRC_ST_CODE0
                                                             : TRC_ST_BODY;
                end
            end
            TRC_ST_BODY: begin
                if (rx_take && rx_data != `TRC_CHAR_CR) begin
                    next_prot_arg = {prot_arg[27:0], hex_val(rx_data)};
                    if (code == `TRC_CMD_TEST && ptr <= `TRC_ECHO_LAST) begin
                        next_ptr = 6'(ptr + 1'b1);
                    end
                end else if (rx_take) begin
                    next_state    = TRC_ST_CODE0;
                    next_kind     = TRC_RESP_DONE;
                    next_resp_len = `TRC_LEN_DONE;
                    next_ptr      = 6'h00;
                    case (code)
                        `TRC_CMD_ACK: begin
                            next_ack_q    = 1'b1;
                            next_resp_len = resp_len;
                        end
                        `TRC_CMD_NACK: begin
                            next_resp_len = resp_len;
                            if (resp_len != 6'h00) begin
                                next_state = TRC_ST_SEND_RD;
                            end
                        end
                        `TRC_CMD_STOP: begin
                            next_prot_busy = 1'b0;
                            next_prot_have = 1'b0;
                            next_abort_q   = 1'b1;
                            next_state     = TRC_ST_BUILD;
                        end
                        `TRC_CMD_CAR_ON: begin
                            next_car   = 1'b1;
                            next_state = TRC_ST_BUILD;
                        end
                        `TRC_CMD_CAR_OFF: begin
                            next_car   = 1'b0;
                            next_state = TRC_ST_BUILD;
                        end
                        `TRC_CMD_TEST: begin
                            next_kind     = TRC_RESP_ECHO;
                            next_resp_len = 6'(ptr + 1'b1);
                            next_state    = TRC_ST_BUILD;
                        end
                        `TRC_CMD_PROTECT: begin
                            next_req_q     = ~prot_busy;
                            next_prot_busy = 1'b1;
                            next_resp_len  = resp_len;
                        end
                        default: begin
                            next_resp_len = resp_len;
                        end
                    endcase
                end
            end
            TRC_ST_BUILD: begin
                next_ptr = 6'(ptr + 1'b1);
                if (ptr == 6'(resp_len - 1'b1)) begin
                    next_ptr   = 6'h00;
                    next_state = TRC_ST_SEND_RD;
                end
            end
            TRC_ST_SEND_RD: begin
                next_state = TRC_ST_SEND_PUSH;
            end
            TRC_ST_SEND_PUSH: begin
                if (fifo_ready) begin
                    next_ptr   = 6'(ptr + 1'b1);
                    next_state = TRC_ST_SEND_RD;
                    if (ptr == 6'(resp_len - 1'b1)) begin
                        next_ptr   = 6'h00;
                        next_state = TRC_ST_CODE0;
                    end
                end
            end
        endcase
    end

    // Register sequencer state
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state     <= TRC_ST_CODE0;
            kind      <= TRC_RESP_DONE;
            code      <= 16'h0000;
            ptr       <= 6'h00;
            resp_len  <= 6'h00;
            prot_busy <= 1'b0;
            prot_have <= 1'b0;
            prot_bits <= 30'h0000_0000;
            prot_arg  <= 32'h0000_0000;
            car       <= 1'b0;
            req_q     <= 1'b0;
            abort_q   <= 1'b0;
            ack_q     <= 1'b0;
        end else if (ce) begin
            state     <= next_state;
            kind      <= next_kind;
            code      <= next_code;
            ptr       <= next_ptr;
            resp_len  <= next_resp_len;
            prot_busy <= next_prot_busy;
            prot_have <= next_prot_have;
            prot_bits <= next_prot_bits;
            prot_arg  <= next_prot_arg;
            car       <= next_car;
            req_q     <= next_req_q;
            abort_q   <= next_abort_q;
            ack_q     <= next_ack_q;
        end
    end

    assign carrier_on    = car;
    assign protect_req   = req_q;
    assign protect_pages = prot_arg;
    assign cmd_busy      = prot_busy;
    assign abort_pulse   = abort_q;
    assign ack_pulse     = ack_q;

    ////////////////////////////////////////////////////////////////////////
    // Response store and output FIFO

    trc_resp_mem #(
        .WIDTH (CW),
        .DEPTH (DEPTH),
        .AW    (6)
    ) u_mem (
        .clk     (clk),
        .ce      (ce),
        .wr_en   (mem_wr),
        .wr_addr (mem_waddr),
        .wr_data (mem_wdata),
        .rd_addr (ptr),
        .rd_data (mem_rdata)
    );

    trc_fifo #(
        .WIDTH (CW),
        .DEPTH (FDEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_b     (rst_b),
        .ce        (ce),
        .in_valid  (fifo_push),
        .in_ready  (fifo_ready),
        .in_data   (mem_rdata),
        .out_valid (tx_valid),
        .out_ready (tx_ready),
        .out_data  (tx_data)
    );

endmodule : trc_cmd
`default_nettype wire

// File: verification/trc_cmd_chk.sv
// Assertion checker for the control command interpreter
`include "trc_consts.svh"
`default_nettype none
module trc_cmd_chk (
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic       ce,
    input wire logic       rx_valid,
    input wire logic       rx_ready,
    input wire logic [7:0] rx_data,
    input wire logic       tx_valid,
    input wire logic       tx_ready,
    input wire logic [7:0] tx_data,
    input wire logic       carrier_on,
    input wire logic       protect_req,
    input wire logic       cmd_busy,
    input wire logic       abort_pulse,
    input wire logic       ack_pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] code;
    logic [15:0] fcode;
    logic [1:0]  cnt;
    logic        fin;
    logic        bare;
    wire logic   take = ce & rx_valid & rx_ready;

    // Frame decoder: command code and end-of-frame pulse
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            code  <= '0;
            fcode <= '0;
            cnt   <= '0;
            fin   <= 1'b0;
            bare  <= 1'b0;
        end else begin
            fin  <= take && rx_data == `TRC_CHAR_CR && cnt >= 2'h2;
            bare <= cnt == 2'h2;
            if (take && rx_data == `TRC_CHAR_CR) begin
                fcode <= code;
                cnt   <= '0;
            end else if (take && cnt < 2'h2) begin
                code <= {code[7:0], rx_data};
                cnt  <= cnt + 2'h1;
            end
        end
    end

    ////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_car_on;
        fin && fcode == `TRC_CMD_CAR_ON |-> ##[0:3] carrier_on;
    endproperty
    a_car_on: assert property (p_car_on)
        else $error("carrier not switched on");
    property p_car_off;
        fin && fcode == `TRC_CMD_CAR_OFF |-> ##[0:3] !carrier_on;
    endproperty
    a_car_off: assert property (p_car_off)
        else $error("carrier not switched off");
    property p_ack;
        fin && fcode == `TRC_CMD_ACK |-> ##[0:3] ack_pulse;
    endproperty
    a_ack: assert property (p_ack)
        else $error("acknowledge not passed on");
    property p_ack_silent;
        fin && bare && fcode == `TRC_CMD_ACK && !tx_valid && !cmd_busy
            |-> !tx_valid [*8];
    endproperty
    a_ack_silent: assert property (p_ack_silent)
        else $error("reply sent for acknowledge");
    property p_abort;
        fin && fcode == `TRC_CMD_STOP |-> ##[0:3] abort_pulse;
    endproperty
    a_abort: assert property (p_abort)
        else $error("abort not signalled");
    property p_abort_idle;
        abort_pulse |-> ##[0:1] !cmd_busy;
    endproperty
    a_abort_idle: assert property (p_abort_idle)
        else $error("busy after abort");
    property p_req;
        fin && fcode == `TRC_CMD_PROTECT && !$past(cmd_busy)
            |-> protect_req;
    endproperty
    a_req: assert property (p_req)
        else $error("protection request missing");
    property p_req_pulse;
        protect_req |=> !protect_req && cmd_busy;
    endproperty
    a_req_pulse: assert property (p_req_pulse)
        else $error("protection request not a pulse");
    property p_tx_hold;
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
    endproperty
    a_tx_hold: assert property (p_tx_hold)
        else $error("reply character dropped");

    // Main scenarios reached
    c_test: cover property (fin && fcode == `TRC_CMD_TEST);
    c_abort: cover property (abort_pulse);
    c_stall: cover property (tx_valid && !tx_ready);
endmodule : trc_cmd_chk
`default_nettype wire

// File: verification/trc_host.sv
// Host controller model: sends frames, collects replies
`default_nettype none
module trc_host (
    input wire logic       clk,
    output var logic       rx_valid,
    input wire logic       rx_ready,
    output var logic [7:0] rx_data,
    input wire logic       tx_valid,
    output var logic       tx_ready,
    input wire logic [7:0] tx_data,
    input wire logic       slow
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got[$];

    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'hA5;
        tx_ready = 1'b0;
    end

    // Send one frame, each character held until taken or for 500 cycles, closed by carriage return
    task automatic send(input string s);
        int w;
        for (int k = 0; k <= s.len(); k++) begin
            rx_valid <= 1'b1;
            rx_data  <= (k == s.len()) ? 8'h0D : s[k];
            w = 0;
            do begin
                @(posedge clk);
                w++;
            end while (!rx_ready && w < 500);
        end
        rx_valid <= 1'b0;
        rx_data  <= ~rx_data;
    endtask : send

    // Reply collection, with optional stalls
    always @(posedge clk) begin
        if (tx_valid && tx_ready) got.push_back(tx_data);
        tx_ready <= slow ? ($urandom_range(3) != 0) : 1'b1;
    end
endmodule : trc_host
`default_nettype wire

// File: verification/trc_cmd_test.sv
// Self-checking bench of the control command interpreter
`default_nettype none
module trc_cmd_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst_b, ce, rx_valid, rx_ready, tx_valid, tx_ready;
    logic        carrier_on, protect_req, protect_done, cmd_busy;
    logic        abort_pulse, ack_pulse, slow;
    logic [7:0]  rx_data, tx_data;
    logic [31:0] protect_pages;
    logic [29:0] protect_status, st;
    int          n_errors, n_compared, cyc;
    string       last, cr, d, e;

    trc_cmd dut (.clk, .rst_b, .ce, .rx_valid, .rx_ready, .rx_data,
        .tx_valid, .tx_ready, .tx_data, .carrier_on, .protect_req,
        .protect_pages, .protect_done, .protect_status, .cmd_busy,
        .abort_pulse, .ack_pulse);
    trc_host host (.clk, .rx_valid, .rx_ready, .rx_data, .tx_valid,
        .tx_ready, .tx_data, .slow);

    // Clock and hang limit
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            n_errors++;
            give_verdict();
        end
    end

    ////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic give_verdict;
        $display("Errors %0d, compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict

    // Reference model of the reply to a frame
    function automatic string reply(input string s);
        case (s.substr(0, 1))
            "10":             return {"00", s.substr(2, s.len() - 1), cr};
            "12":             return last;
            "13", "14", "15": return {"00", cr};
            default:          return "";
        endcase
    endfunction : reply

    function automatic string hexs(input logic [31:0] v);
        string      s = "00000000";
        logic [3:0] b;
        for (int i = 0; i < 8; i++) begin
            b = v[31 - 4 * i -: 4];
            s[i] = (b < 4'hA) ? 8'h30 + b : 8'h37 + b;
        end
        return s;
    endfunction : hexs

    task automatic expect_reply(input string x);
        int w = 0;
        while (host.got.size() < x.len() && w < 3000) begin
            @(posedge clk);
            w++;
        end
        repeat (30) @(posedge clk);
        check(host.got.size(), x.len());
        for (int i = 0; i < x.len() && i < host.got.size(); i++)
            check(host.got[i], x[i]);
        host.got.delete();
        if (x != "") last = x;
    endtask : expect_reply

    task automatic frame(input string s);
        string x = reply(s);
        host.send(s);
        expect_reply(x);
    endtask : frame

    ////////////////////////////////////////
    // Main sequence
    initial begin
        rst_b = 1'b0;
        ce = 1'b1;
        protect_done = 1'b0;
        protect_status = '0;
        slow = 1'b0;
        cr = "\015";
        last = "";
        void'($urandom(32'h2251));
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        frame("12");
        for (int r = 0; r < 2; r++) begin
            slow <= r[0];
            frame("14");
            check(carrier_on, 1);
            frame("12");
            frame("15");
            check(carrier_on, 0);
            frame("11");
            frame("99");
        end
        for (int k = 0; k < 6; k++) begin
            d = "";
            repeat ($urandom_range(20, 1)) d = {d, " "};
            for (int j = 0; j < d.len(); j++)
                d[j] = 8'($urandom_range(8'h7E, 8'h20));
            frame({"10", d});
            frame("12");
        end
        for (int k = 0; k < 3; k++) begin
            st = (k == 0) ? '1 : 30'($urandom);
            host.send("0500A1B2C3D4");
            expect_reply("");
            check(protect_pages, 32'hA1B2C3D4);
            frame("12");
            protect_status <= st;
            protect_done <= 1'b1;
            @(posedge clk);
            protect_done <= 1'b0;
            expect_reply({"00", hexs({st, 2'b00}), cr});
            frame("11");
            frame("12");
        end
        host.send("0500000000FF");
        expect_reply("");
        frame("13");
        check(cmd_busy, 0);
        protect_done <= 1'b1;
        @(posedge clk);
        protect_done <= 1'b0;
        expect_reply("");
        frame("11");
        give_verdict();
    end
endmodule : trc_cmd_test

bind trc_cmd trc_cmd_chk u_chk (.clk, .rst_b, .ce, .rx_valid, .rx_ready,
    .rx_data, .tx_valid, .tx_ready, .tx_data, .carrier_on, .protect_req,
    .cmd_busy, .abort_pulse, .ack_pulse);
`default_nettype wire
